//--- core/cmd_defs.svh
// constants and command codes for the dram command and cke decoder
// assumes a single 10 MHz core clock; included by the package and modules
//
// Notes on behaviour
// - a started read burst always runs to its end; no command cuts it
// - self refresh exit follows the pins, not a registered condition
// - nop registers nothing and leaves running operations alone
// - deselect blocks new commands; running operations continue like nop
// - no internal refresh runs while in power-down
// - action comes from cke at n-1, cke at n, command and prior state
// - low-low cke holds power-down or self refresh; low-high with des/nop exits
// - high-low cke: des/nop enters power-down, refresh with idle banks self refresh
// - idle only with banks closed, no burst, cke high, timings met
// - long calibration runs engine then loads drivers and termination
// - short calibration finishes within 64 clock cycles
// - activate opens row on address in bank on three bank bits
// - read start column comes from low three address bits
// - address bit 10 on read asks for precharge at burst end
// - with on-the-fly enabled, address bit 12 low chops to four, high eight
// - read is cs low, ras high, cas low, we high, cke high both edges
// - every command decodes from cs, ras, cas and we at the edge; only read also needs cke
// - reset low acts synchronously at the clock edge; held high in normal operation
`ifndef CMD_DEFS_SVH
`define CMD_DEFS_SVH
`define BANKS          8
`define BANK_W         3
`define ROW_W          16
`define COL_LO_W       3
`define AP_BIT         10
`define OTF_BIT        12
`define BL8_BEATS      4'h8
`define BC4_BEATS      4'h4
`define ZQCS_CYC       11'h040
`define ZQ_OPER_CYC    11'h100
`define ZQ_INIT_CYC    11'h200
`define CKE_MIN_CYC    3'h3
`endif

//--- core/cmd_pkg.sv
// types shared by the command decoder
// assumes cmd_defs.svh for numeric constants
`include "cmd_defs.svh"
package cmd_pkg;
   typedef enum logic [3:0] {
      cmd_des, cmd_nop, cmd_mrs, cmd_ref, cmd_pre, cmd_act,
      cmd_wr, cmd_rd, cmd_zq, cmd_bad
   } cmd_e;
   typedef enum logic [2:0] {
      st_idle, st_active, st_act_pd, st_pre_pd, st_self_ref
   } pwr_e;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } pins_s;
   typedef struct packed {
      logic [`BANK_W-1:0]   bank;
      logic [`COL_LO_W-1:0] col;
      logic                 auto_pre;
      logic                 bl8;
   } rd_s;
endpackage : cmd_pkg

//--- core/cmd_decode.sv
// pure decoder from sampled command pins to a command code
// assumes pins and cke are synchronous to the core clock
`timescale 1ns/1ps
`include "cmd_defs.svh"
module cmd_decode
   import cmd_pkg::*;
(
   input  wire pins_s pins_i,
   input  wire logic  cke_prev_i,
   input  wire logic  cke_i,
   output cmd_e       cmd_o
);
   always_comb begin
      if (pins_i.cs_n) begin
         cmd_o = cmd_des;
      end else begin
         case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n})
            3'h7: cmd_o = cmd_nop;
            3'h0: cmd_o = cmd_mrs;
            3'h1: cmd_o = cmd_ref;
            3'h2: cmd_o = cmd_pre;
            3'h3: cmd_o = cmd_act;
            3'h4: cmd_o = cmd_wr;
            3'h5: cmd_o = (cke_prev_i && cke_i) ? cmd_rd : cmd_bad;
            3'h6: cmd_o = cmd_zq;
            default: cmd_o = cmd_bad;
         endcase
      end
   end
endmodule : cmd_decode

//--- core/dram_cmd_core.sv
// command interpreter and cke power state machine of the dram
// assumes controller keeps legal command sequences and cke hold times
`timescale 1ns/1ps
`include "cmd_defs.svh"
module dram_cmd_core
   import cmd_pkg::*;
#(
   parameter int BANKS = `BANKS,
   parameter int ROW_W = `ROW_W
)(
   input  wire logic                core_clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                ce_i,
   input  wire logic                cke_i,
   input  wire pins_s               pins_i,
   input  wire logic [`BANK_W-1:0]  ba_i,
   input  wire logic [ROW_W-1:0]    addr_i,
   input  wire logic                otf_en_i,
   input  wire logic                mr_bl8_i,
   output logic [BANKS-1:0]         bank_open_o,
   output logic [ROW_W-1:0]         open_row_o,
   output logic                     burst_busy_o,
   output rd_s                      rd_info_o,
   output logic                     pre_pd_o,
   output logic                     act_pd_o,
   output logic                     self_ref_o,
   output logic                     idle_o,
   output logic                     refresh_go_o,
   output logic                     zq_busy_o,
   output logic                     zq_load_o
);
   ////////////////////////////////////////////////////////////////////////
   cmd_e             cmd;
   pwr_e             pwr;
   logic             cke_prev;
   logic [3:0]       beats;
   logic             ap_pend;
   logic [`BANK_W-1:0] ap_bank;
   logic [10:0]      zq_cnt;
   logic             zq_init_done;
   logic [2:0]       cke_hold;
   logic [ROW_W-1:0] rows [BANKS];
   logic             powered;
   logic             sr_exit;

   cmd_decode u_dec (
      .pins_i     (pins_i),
      .cke_prev_i (cke_prev),
      .cke_i      (cke_i),
      .cmd_o      (cmd)
   );

   function automatic logic is_quiet(input cmd_e c);
      is_quiet = (c == cmd_des) || (c == cmd_nop);
   endfunction : is_quiet

   // commands execute only with cke high on both edges and in a powered state
   assign powered = cke_prev && cke_i && (pwr == st_idle || pwr == st_active);

   // self refresh ends straight from the pin, no registered stage in the path
   assign sr_exit = (pwr == st_self_ref) && cke_i;
   assign self_ref_o = (pwr == st_self_ref) && !cke_i;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cke_prev <= 1'b0;
      end else if (ce_i) begin
         cke_prev <= cke_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cke_hold <= 3'h0;
      end else if (ce_i) begin
         if (cke_i != cke_prev) begin
            cke_hold <= 3'h1;
         end else if (cke_hold != `CKE_MIN_CYC) begin
            cke_hold <= cke_hold + 3'h1;
         end
      end
   end

   // power state machine
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pwr <= st_idle;
      end else if (ce_i) begin
         case (pwr)
            st_idle, st_active: begin
               if (cke_prev && !cke_i) begin
                  if (cmd == cmd_ref && pwr == st_idle && !burst_busy_o) begin
                     pwr <= st_self_ref;
                  end else if (is_quiet(cmd)) begin
                     pwr <= (|bank_open_o) ? st_act_pd : st_pre_pd;
                  end
               end else begin
                  pwr <= (|bank_open_o || cmd == cmd_act) ? st_active : st_idle;
               end
            end
            st_act_pd, st_pre_pd: begin
               // low-low holds, low-high with des/nop leaves
               if (!cke_prev && cke_i && is_quiet(cmd)) begin
                  pwr <= (pwr == st_act_pd) ? st_active : st_idle;
               end
            end
            st_self_ref: begin
               if (sr_exit && is_quiet(cmd)) begin
                  pwr <= st_idle;
               end
            end
            default: pwr <= st_idle;
         endcase
      end
   end

   assign pre_pd_o = (pwr == st_pre_pd);
   assign act_pd_o = (pwr == st_act_pd);
   // refresh only on a command in a powered state, never in power-down
   assign refresh_go_o = ce_i && powered && cmd == cmd_ref;

   ////////////////////////////////////////////////////////////////////////
   // bank table; des and nop fall through untouched
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         bank_open_o <= '0;
      end else if (ce_i) begin
         if (powered && cmd == cmd_act) begin
            bank_open_o[ba_i] <= 1'b1;
            rows[ba_i]        <= addr_i;
         end else if (powered && cmd == cmd_pre) begin
            if (addr_i[`AP_BIT]) begin
               bank_open_o <= '0;
            end else begin
               bank_open_o[ba_i] <= 1'b0;
            end
         end else if (ap_pend && beats == 4'h1) begin
            bank_open_o[ap_bank] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         open_row_o <= '0;
      end else if (ce_i) begin
         open_row_o <= rows[ba_i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read burst; a new read is ignored while one runs so none is cut short
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         beats     <= 4'h0;
         ap_pend   <= 1'b0;
         ap_bank   <= '0;
         rd_info_o <= '0;
      end else if (ce_i) begin
         if (powered && cmd == cmd_rd && beats == 4'h0) begin
            rd_info_o.bank     <= ba_i;
            rd_info_o.col      <= addr_i[`COL_LO_W-1:0];
            rd_info_o.auto_pre <= addr_i[`AP_BIT];
            rd_info_o.bl8      <= otf_en_i ? addr_i[`OTF_BIT] : mr_bl8_i;
            beats   <= (otf_en_i ? addr_i[`OTF_BIT] : mr_bl8_i) ?
                       `BL8_BEATS : `BC4_BEATS;
            ap_pend <= addr_i[`AP_BIT];
            ap_bank <= ba_i;
         end else if (beats != 4'h0) begin
            beats <= beats - 4'h1;
            if (beats == 4'h1) begin
               ap_pend <= 1'b0;
            end
         end
      end
   end

   assign burst_busy_o = (beats != 4'h0);

   ////////////////////////////////////////////////////////////////////////
   // calibration engine timer; first long one uses the init window
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         zq_cnt       <= 11'h0;
         zq_init_done <= 1'b0;
         zq_load_o    <= 1'b0;
      end else if (ce_i) begin
         zq_load_o <= 1'b0;
         if (powered && cmd == cmd_zq && zq_cnt == 11'h0) begin
            if (addr_i[`AP_BIT]) begin
               zq_cnt <= zq_init_done ? `ZQ_OPER_CYC : `ZQ_INIT_CYC;
               zq_init_done <= 1'b1;
            end else begin
               zq_cnt <= `ZQCS_CYC;
            end
         end else if (zq_cnt != 11'h0) begin
            zq_cnt <= zq_cnt - 11'h1;
            if (zq_cnt == 11'h1) begin
               zq_load_o <= 1'b1;
            end
         end
      end
   end

   assign zq_busy_o = (zq_cnt != 11'h0);

   // idle: banks closed, no burst, cke high, exit timing met
   assign idle_o = (pwr == st_idle) && !(|bank_open_o) && !burst_busy_o
                   && cke_i && cke_prev && (cke_hold == `CKE_MIN_CYC)
                   && !zq_busy_o;

   ////////////////////////////////////////////////////////////////////////
   burst_len_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && $rose(burst_busy_o) && rd_info_o.bl8 |-> ##1 (ce_i [*7]) |-> burst_busy_o)
      else $error("burst ended early");
   zq_short_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(zq_busy_o) && zq_cnt == `ZQCS_CYC |-> ##[1:300] zq_load_o || !ce_i)
      else $error("short calibration overran");
   pd_no_ref_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (pre_pd_o || act_pd_o) |-> !refresh_go_o)
      else $error("refresh in power-down");
   pd_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && pre_pd_o && !cke_prev && !cke_i |=> pre_pd_o)
      else $error("power-down left with cke low");
   pd_entry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && pwr == st_active && |bank_open_o && cke_prev && !cke_i
      && is_quiet(cmd) |=> act_pd_o)
      else $error("active power-down not entered");
   sr_entry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && pwr == st_idle && !burst_busy_o && cke_prev && !cke_i
      && cmd == cmd_ref |=> pwr == st_self_ref)
      else $error("self refresh not entered");
   idle_ok_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      idle_o |-> bank_open_o == '0 && !burst_busy_o && cke_i)
      else $error("idle with work pending");
   act_open_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && powered && cmd == cmd_act |=> bank_open_o[$past(ba_i)])
      else $error("activate did not open bank");
   rd_col_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && powered && cmd == cmd_rd && !burst_busy_o
      |=> rd_info_o.col == $past(addr_i[2:0]))
      else $error("read column wrong");
   quiet_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && is_quiet(cmd) && !burst_busy_o && !ap_pend |=> $stable(bank_open_o))
      else $error("nop changed banks");
   rd_cover_c:  cover property (@(posedge core_clk_i) $rose(burst_busy_o));
   sr_cover_c:  cover property (@(posedge core_clk_i) $fell(pwr == st_self_ref));
   pd_cover_c:  cover property (@(posedge core_clk_i) $rose(act_pd_o));
   zq_cover_c:  cover property (@(posedge core_clk_i) zq_load_o);
endmodule : dram_cmd_core

//--- sim/ctrl_model.sv
// controller stand-in driving the command, address and cke pins
// assumes the bench calls its tasks from one process, right after a clock edge
`timescale 1ns/1ps
`include "cmd_defs.svh"
module ctrl_model
   import cmd_pkg::*;
(
   input  wire logic           clk_i,
   output logic                cke_o,
   output pins_s               pins_o,
   output logic [`BANK_W-1:0]  ba_o,
   output logic [`ROW_W-1:0]   addr_o
);
   initial begin
      cke_o  = 1'b1;
      pins_o = 4'h7;
      ba_o   = 3'h0;
      addr_o = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // address is don't care in nop, so it toggles: a stale value never looks valid
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk_i);
         pins_o <= 4'h7;
         addr_o <= ~addr_o;
      end
   endtask : idle
   // cke change with nop only, no hold here; caller holds the level
   task automatic set_cke(input logic k);
      @(posedge clk_i);
      cke_o  <= k;
      pins_o <= 4'h7;
   endtask : set_cke
   task automatic send(input pins_s p, input logic [2:0] b, input logic [15:0] a,
                       input logic k);
      @(posedge clk_i);
      pins_o <= p;
      ba_o   <= b;
      addr_o <= a;
      cke_o  <= k;
      idle(1);
   endtask : send
endmodule : ctrl_model

//--- sim/tb_top.sv
// self-checking bench for the dram command and cke decoder
// assumes ctrl_model stands in for the controller on the command pins
`timescale 1ns/1ps
`include "cmd_defs.svh"
module tb_top
   import cmd_pkg::*;
;
   localparam pins_s ACT_P = 4'h3, RD_P = 4'h5, NOP_P = 4'h7, REF_P = 4'h1;
   localparam pins_s PRE_P = 4'h2, ZQ_P = 4'h6, DES_P = 4'hb;
   logic        clk = 1'b0, rst_n = 1'b0, otf_en = 1'b0, mr_bl8 = 1'b0, cke, ce = 1'b1;
   pins_s       pins;
   logic [2:0]  ba;
   logic [15:0] addr, open_row;
   logic [7:0]  bank_open;
   rd_s         rd_info;
   logic        busy, pre_pd, act_pd, self_ref, idle, ref_go, zq_busy, zq_load;
   int          miscompares = 0, check_count = 0, cyc = 0, bcnt, zcnt, lcnt, rcnt;
   initial begin
      forever #50 clk = ~clk;
   end
   ctrl_model m (.clk_i(clk), .cke_o(cke), .pins_o(pins), .ba_o(ba), .addr_o(addr));
   dram_cmd_core dut (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .cke_i(cke),
      .pins_i(pins), .ba_i(ba), .addr_i(addr), .otf_en_i(otf_en), .mr_bl8_i(mr_bl8),
      .bank_open_o(bank_open), .open_row_o(open_row), .burst_busy_o(busy),
      .rd_info_o(rd_info), .pre_pd_o(pre_pd), .act_pd_o(act_pd), .self_ref_o(self_ref),
      .idle_o(idle), .refresh_go_o(ref_go), .zq_busy_o(zq_busy), .zq_load_o(zq_load));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string s);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask : chk_val
   task automatic chk_cnt(input int got, input int lo, input int hi, input string s);
      check_count++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("CHECK FAILED t=%0t %s count %0d", $time, s, got);
      end
   endtask : chk_cnt
   // edge-sampled counts, so comb pulses are seen in their own cycle
   always @(posedge clk) begin
      cyc++;
      if (busy === 1'b1) bcnt++;
      if (zq_busy === 1'b1) zcnt++;
      if (zq_load === 1'b1) lcnt++;
      if (ref_go === 1'b1) rcnt++;
      if (cyc == 4000) begin
         miscompares++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_zq();
      int w[3] = '{`ZQ_INIT_CYC, `ZQCS_CYC, `ZQ_OPER_CYC};
      for (int i = 0; i < 3; i++) begin
         zcnt = 0;
         lcnt = 0;
         m.send(ZQ_P, 3'h0, (i == 1) ? 16'h0000 : 16'h0400, 1'b1);
         m.idle(w[i] + 8);
         chk_cnt(lcnt, 1, 1, "zq load");
         chk_cnt(zcnt, w[i] - 1, w[i] + 1, "zq busy");
      end
      $display("test zq done");
   endtask : t_zq
   task automatic t_des();
      m.send(DES_P, 3'h1, 16'h0001, 1'b1);
      m.idle(2);
      #1;
      chk_val(bank_open, 8'h00, "des opened bank");
      chk_val(idle, 1'b1, "not idle");
      $display("test deselect done");
   endtask : t_des
   // clock enable low: an activate must leave no trace
   task automatic t_freeze();
      @(posedge clk);
      ce <= 1'b0;
      m.send(ACT_P, 3'h1, 16'h0011, 1'b1);
      m.idle(2);
      #1;
      chk_val(bank_open, 8'h00, "frozen act");
      @(posedge clk);
      ce <= 1'b1;
      m.idle(4);
      #1;
      chk_val(idle, 1'b1, "idle after freeze");
      $display("test freeze done");
   endtask : t_freeze
   task automatic t_read();
      otf_en <= 1'b1;
      m.send(ACT_P, 3'h2, 16'h1234, 1'b1);
      m.idle(1);
      #1;
      chk_val(bank_open, 8'h04, "act bank");
      chk_val(open_row, 16'h1234, "act row");
      chk_val(idle, 1'b0, "idle with open bank");
      bcnt = 0;
      m.send(RD_P, 3'h2, 16'h1005, 1'b1);
      m.send(RD_P, 3'h2, 16'h0002, 1'b1);
      m.idle(12);
      chk_cnt(bcnt, 8, 8, "bl8 burst cut");
      chk_val(rd_info, 8'h55, "read info");
      chk_val(bank_open, 8'h04, "row closed");
      $display("test read done");
   endtask : t_read
   task automatic t_chop();
      bcnt = 0;
      m.send(RD_P, 3'h2, 16'h0403, 1'b1);
      m.idle(8);
      chk_cnt(bcnt, 4, 4, "chop burst");
      chk_val(bank_open, 8'h00, "auto precharge");
      otf_en <= 1'b0;
      mr_bl8 <= 1'b1;
      m.send(ACT_P, 3'h2, 16'h0777, 1'b1);
      bcnt = 0;
      m.send(RD_P, 3'h2, 16'h0000, 1'b1);
      m.idle(12);
      chk_cnt(bcnt, 8, 8, "fixed burst");
      m.send(PRE_P, 3'h0, 16'h0400, 1'b1);
      $display("test chop done");
   endtask : t_chop
   task automatic t_pdown();
      m.send(ACT_P, 3'h5, 16'h0000, 1'b1);
      m.send(NOP_P, 3'h5, 16'h0000, 1'b0);
      m.idle(3);
      #1;
      chk_val(act_pd, 1'b1, "active pd");
      rcnt = 0;
      m.send(REF_P, 3'h5, 16'h0000, 1'b0);
      m.idle(2);
      #1;
      chk_cnt(rcnt, 0, 0, "refresh in pd");
      chk_val({act_pd, bank_open}, 9'h120, "pd left");
      m.send(NOP_P, 3'h5, 16'h0000, 1'b1);
      m.idle(3);
      #1;
      chk_val(act_pd, 1'b0, "pd exit");
      m.send(PRE_P, 3'h0, 16'h0400, 1'b1);
      m.send(DES_P, 3'h0, 16'h0000, 1'b0);
      m.idle(3);
      #1;
      chk_val(pre_pd, 1'b1, "precharge pd");
      m.send(NOP_P, 3'h0, 16'h0000, 1'b1);
      m.idle(3);
      #1;
      chk_val(pre_pd, 1'b0, "pd exit");
      $display("test power down done");
   endtask : t_pdown
   task automatic t_sref();
      rcnt = 0;
      m.send(REF_P, 3'h0, 16'h0000, 1'b1);
      m.idle(2);
      #1;
      chk_cnt(rcnt, 1, 1, "refresh");
      m.send(REF_P, 3'h0, 16'h0000, 1'b0);
      m.idle(3);
      #1;
      chk_val(self_ref, 1'b1, "self refresh");
      m.set_cke(1'b1);
      #1;
      chk_val(self_ref, 1'b0, "sr exit");
      m.idle(4);
      #1;
      chk_val(idle, 1'b1, "idle after exit");
      $display("test self refresh done");
   endtask : t_sref
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      m.idle(4);
      t_zq();
      t_des();
      t_freeze();
      t_read();
      t_chop();
      t_pdown();
      t_sref();
      give_verdict();
   end
endmodule : tb_top
